// >>> src/mac_side_regs_defines.vh
// constants for the mac-side control and status register bank
//**********************************************************************
// How it works
// R1 - manager writes 0x0003 into first bias word
// R2 - manager writes 0x0000 into second bias word
// R3 - bits 15:14 size transmit elastic fifo span
// R4 - bits 9 and 3 act after software reset
// R5 - 125m clock disable follows strap edges
// R6 - 50m clock disable follows strap edges
// R7 - bit 3 high keeps receive clock running
// R8 - manager sets reserved bit 7, others zero
// R9 - enable bits 7, 3, 2, reset to zero
// R10 - overflow or underflow latches status bit 7
// R11 - idle insertion latches status bit 3
// R12 - idle deletion latches status bit 2
// R13 - reserved status bits always read zero
// R14 - status read clears bits, new event wins
// R15 - interrupt while enabled status bit set
//**********************************************************************
`ifndef MAC_SIDE_REGS_DEFINES_VH
`define MAC_SIDE_REGS_DEFINES_VH

// pages and register numbers
`define PAGE_BIAS          8'h00
`define PAGE_MAC           8'h02
`define REG_MAC_CTRL_ONE   5'h10
`define REG_IRQ_ENABLE     5'h12
`define REG_EVT_STATUS     5'h13
`define REG_BIAS_ONE       5'h1d
`define REG_BIAS_TWO       5'h1e

// control word fields
`define CTRL_FIFO_HI       15
`define CTRL_FIFO_LO       14
`define CTRL_CLK125_OFF    9
`define CTRL_CLK50_OFF     8
`define CTRL_RSVD_SEVEN    7
`define CTRL_RXCLK_KEEP    3

// status and enable bit positions
`define EVT_XRUN           7
`define EVT_IDLE_INS       3
`define EVT_IDLE_DEL       2
`define EVT_MASK           16'h008c

// reset values
`define CTRL_RESET         16'h0088
`define IRQ_EN_RESET       16'h0000
`define BIAS_ONE_RESET     16'h0000
`define BIAS_TWO_RESET     16'h0000

// fifo span: 16 bits plus 8 per step of the depth field
`define FIFO_SPAN_BASE     6'h10
`define FIFO_SPAN_STEP     6'h08

`endif

// >>> src/strap_follow_bit.v
// one register bit that loads from a strap and follows its edges
`timescale 1ns/1ps
module strap_follow_bit
(
  input  wire sys_clk,
  input  wire nrst,
  input  wire strap_in,
  input  wire wr_en,
  input  wire wr_val,
  output reg  bit_q
);

  reg strap_prev_q; // strap as seen one clock ago

  // reset loads the strap level; later an edge of the strap wins over a
  // write landing in the same cycle, since the strap is the board's intent
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      bit_q        <= strap_in;   // [R5] [R6]
      strap_prev_q <= strap_in;
    end
    else
    begin
      strap_prev_q <= strap_in;
      if (strap_in && !strap_prev_q)
      begin
        bit_q <= 1'b1;            // rising strap sets [R5] [R6]
      end
      else if (!strap_in && strap_prev_q)
      begin
        bit_q <= 1'b0;            // falling strap clears [R5] [R6]
      end
      else if (wr_en)
      begin
        bit_q <= wr_val;
      end
    end
  end

endmodule

// >>> src/mac_side_regs.v
// mac-side control, interrupt-enable, status and bias register bank
`timescale 1ns/1ps
`include "mac_side_regs_defines.vh"
module mac_side_regs
(
  input  wire        sys_clk,
  input  wire        nrst,
  input  wire        sw_reset,
  input  wire [7:0]  reg_page,
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  input  wire        strap_clock_125m_off,
  input  wire        strap_clock_50m_off,
  input  wire        gigabit_mode,
  input  wire        power_down_req,
  input  wire        energy_detect,
  input  wire        fifo_xrun_evt,
  input  wire        idle_ins_evt,
  input  wire        idle_del_evt,
  output reg  [5:0]  tx_fifo_span,
  output reg         gated_clock_125m_out,
  output reg         gated_clock_50m_out,
  output reg         rx_clk_run,
  output reg  [15:0] bias_one_out,
  output reg  [15:0] bias_two_out,
  output reg         mgmt_irq
);

  //********************************************************************
  // decode
  //********************************************************************

  // true when the access targets the given page and register number
  function hit;
    input [7:0] page;
    input [4:0] addr;
    input [7:0] want_page;
    input [4:0] want_addr;
    begin
      hit = (page == want_page) && (addr == want_addr);
    end
  endfunction

  wire wr_ctrl   = reg_wr_en && hit(reg_page, reg_addr, `PAGE_MAC, `REG_MAC_CTRL_ONE);
  wire wr_irq_en = reg_wr_en && hit(reg_page, reg_addr, `PAGE_MAC, `REG_IRQ_ENABLE);
  wire wr_bias1  = reg_wr_en && hit(reg_page, reg_addr, `PAGE_BIAS, `REG_BIAS_ONE);
  wire wr_bias2  = reg_wr_en && hit(reg_page, reg_addr, `PAGE_BIAS, `REG_BIAS_TWO);
  wire rd_status = reg_rd_en && hit(reg_page, reg_addr, `PAGE_MAC, `REG_EVT_STATUS);

  //********************************************************************
  // stored words
  //********************************************************************

  reg  [15:0] ctrl_q;            // control word except the strap bits
  reg  [15:0] irq_en_q;          // interrupt enable word
  reg  [15:0] bias_one_q;        // first analog bias word
  reg  [15:0] bias_two_q;        // second analog bias word
  reg  [2:0]  evt_q;             // latched events: over/underflow, idle in, idle out
  wire [15:0] status_word;       // status word as read, reserved bits tied 0
  reg         clk125_off_eff_q;  // disable in force on the 125m output
  reg         rx_keep_eff_q;     // receive clock keep-alive in force
  wire [1:0]  strap_bit;         // strap-following control bits 9 and 8
  wire [15:0] ctrl_view;         // control word as software reads it

  // the bias words are only stored; loading 0x0003 and 0x0000 at bring-up
  // is up to the manager, so the reset value is left neutral [R1] [R2]
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      bias_one_q <= `BIAS_ONE_RESET;
      bias_two_q <= `BIAS_TWO_RESET;
    end
    else
    begin
      if (wr_bias1)
      begin
        bias_one_q <= reg_wdata;       // [R1]
      end
      if (wr_bias2)
      begin
        bias_two_q <= reg_wdata;       // [R2]
      end
    end
  end

  // control word; reserved bits are stored as written, bit 7 comes back
  // to 1 on software reset so a careless write cannot stick
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ctrl_q <= `CTRL_RESET;
    end
    else if (sw_reset)
    begin
      ctrl_q[`CTRL_RSVD_SEVEN] <= 1'b1; // [R8]
    end
    else if (wr_ctrl)
    begin
      ctrl_q <= reg_wdata;
    end
  end

  // enable word, only the three event positions are writable
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      irq_en_q <= `IRQ_EN_RESET;               // [R9]
    end
    else if (wr_irq_en)
    begin
      irq_en_q <= reg_wdata & `EVT_MASK;       // [R9]
    end
  end

  //********************************************************************
  // strap-following clock disables
  //********************************************************************

  wire [1:0] strap_pin = {strap_clock_125m_off, strap_clock_50m_off};
  wire [1:0] strap_wv  = {reg_wdata[`CTRL_CLK125_OFF], reg_wdata[`CTRL_CLK50_OFF]};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_strap
      strap_follow_bit u_bit
      (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .strap_in (strap_pin[g]),
        .wr_en    (wr_ctrl && !sw_reset),
        .wr_val   (strap_wv[g]),
        .bit_q    (strap_bit[g])
      );
    end
  endgenerate

  assign ctrl_view = {ctrl_q[15:10], strap_bit[1], strap_bit[0], ctrl_q[7:0]};

  // disruptive bits: the stored value only reaches the hardware when a
  // software reset follows, so a half-done setup never glitches a clock
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      clk125_off_eff_q <= strap_clock_125m_off;       // [R5]
      rx_keep_eff_q    <= 1'b1;                       // [R7]
    end
    else if (sw_reset)
    begin
      clk125_off_eff_q <= strap_bit[1];               // [R4]
      rx_keep_eff_q    <= ctrl_q[`CTRL_RXCLK_KEEP];   // [R4]
    end
  end

  // clock outputs: held low while disabled, otherwise toggling
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      gated_clock_125m_out <= 1'b0;
      gated_clock_50m_out  <= 1'b0;
    end
    else
    begin
      gated_clock_125m_out <= clk125_off_eff_q ? 1'b0 : ~gated_clock_125m_out; // [R5]
      gated_clock_50m_out  <= strap_bit[0] ? 1'b0 : ~gated_clock_50m_out;      // [R6]
    end
  end

  // receive clock may stop only when keep-alive is off and a power-down
  // or energy-detect state asks for it
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      rx_clk_run <= 1'b1;
    end
    else
    begin
      rx_clk_run <= rx_keep_eff_q || !(power_down_req || energy_detect); // [R7]
    end
  end

  // elastic fifo half-span in bits; outside gigabit mode the field has
  // no meaning and the smallest span is reported
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tx_fifo_span <= `FIFO_SPAN_BASE;
    end
    else if (gigabit_mode)
    begin
      case (ctrl_q[`CTRL_FIFO_HI:`CTRL_FIFO_LO])
        2'h0:    tx_fifo_span <= 6'h10;  // [R3]
        2'h1:    tx_fifo_span <= 6'h18;  // [R3]
        2'h2:    tx_fifo_span <= 6'h20;  // [R3]
        default: tx_fifo_span <= 6'h28;  // [R3]
      endcase
    end
    else
    begin
      tx_fifo_span <= `FIFO_SPAN_BASE;
    end
  end

  //********************************************************************
  // latched event status
  //********************************************************************

  wire [2:0] evt_in  = {fifo_xrun_evt, idle_ins_evt, idle_del_evt};

  // each bit latches high on its event; a status read or software reset
  // clears it, but an event in that same cycle keeps it set
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_evt
      always @(posedge sys_clk)
      begin
        if (!nrst)
        begin
          evt_q[g] <= 1'b0;                             // [R10] [R11] [R12]
        end
        else if (evt_in[g])
        begin
          evt_q[g] <= 1'b1;                             // [R10] [R11] [R12] [R14]
        end
        else if (rd_status || sw_reset)
        begin
          evt_q[g] <= 1'b0;                             // [R14] [R10]
        end
      end
    end
  endgenerate

  // reserved status bits are tied to zero, so no flop can ever set them;
  // the three latches sit at bits 7, 3 and 2
  assign status_word = {8'h00, evt_q[2], 3'h0, evt_q[1], evt_q[0], 2'h0}; // [R13]

  // interrupt while any enabled status bit is latched
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      mgmt_irq <= 1'b0;
    end
    else
    begin
      mgmt_irq <= |(status_word & irq_en_q & `EVT_MASK);   // [R15]
    end
  end

  //********************************************************************
  // read port and plain outputs
  //********************************************************************

  // read data is registered; the status word returned is the value
  // before the read-clear, unmapped numbers return zero
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd_en;
      if (!reg_rd_en)
      begin
        reg_rdata <= 16'h0000;
      end
      else if (hit(reg_page, reg_addr, `PAGE_MAC, `REG_MAC_CTRL_ONE))
      begin
        reg_rdata <= ctrl_view;
      end
      else if (hit(reg_page, reg_addr, `PAGE_MAC, `REG_IRQ_ENABLE))
      begin
        reg_rdata <= irq_en_q;
      end
      else if (rd_status)
      begin
        reg_rdata <= status_word & `EVT_MASK;           // [R13]
      end
      else if (hit(reg_page, reg_addr, `PAGE_BIAS, `REG_BIAS_ONE))
      begin
        reg_rdata <= bias_one_q;
      end
      else if (hit(reg_page, reg_addr, `PAGE_BIAS, `REG_BIAS_TWO))
      begin
        reg_rdata <= bias_two_q;
      end
      else
      begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  // bias words driven to the analog side from flops
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      bias_one_out <= `BIAS_ONE_RESET;
      bias_two_out <= `BIAS_TWO_RESET;
    end
    else
    begin
      bias_one_out <= bias_one_q;
      bias_two_out <= bias_two_q;
    end
  end

endmodule

// >>> verification/mac_side_regs_chk.sv
// port assertions for the mac-side register bank
`timescale 1ns/1ps
module mac_side_regs_chk
(
  input wire        sys_clk,
  input wire        nrst,
  input wire        sw_reset,
  input wire [7:0]  reg_page,
  input wire [4:0]  reg_addr,
  input wire        reg_rd_en,
  input wire [15:0] reg_rdata,
  input wire        reg_rvalid,
  input wire        strap_clock_50m_off,
  input wire        gigabit_mode,
  input wire        fifo_xrun_evt,
  input wire        idle_ins_evt,
  input wire        idle_del_evt,
  input wire [5:0]  tx_fifo_span,
  input wire        gated_clock_125m_out,
  input wire        gated_clock_50m_out,
  input wire        mgmt_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // status read strobe and any event
  wire st_rd = reg_rd_en && reg_page == 8'h02 && reg_addr == 5'h13;
  wire any_evt = fifo_xrun_evt | idle_ins_evt | idle_del_evt;
  // nothing may clear the bit between event and read
  sequence s_evt_read(e);
    e ##1 (!st_rd && !sw_reset) ##1 st_rd;
  endsequence
  sequence s_quiet;
    !sw_reset [*3];
  endsequence
  property p_span; !gigabit_mode [*2] |-> tx_fifo_span == 6'h10; endproperty
  property p_rsvd; st_rd |=> reg_rvalid && (reg_rdata & 16'hff73) == 16'h0000; endproperty
  property p_xrun; s_evt_read(fifo_xrun_evt) |=> reg_rdata[7]; endproperty
  property p_ins; s_evt_read(idle_ins_evt) |=> reg_rdata[3]; endproperty
  property p_del; s_evt_read(idle_del_evt) |=> reg_rdata[2]; endproperty
  property p_clear; st_rd && !any_evt |-> ##2 !mgmt_irq; endproperty
  property p_clk50; $rose(strap_clock_50m_off) |-> ##2 !gated_clock_50m_out; endproperty
  // a pending disable must not stop the clock without a software reset
  property p_clk125; s_quiet ##0 $fell(gated_clock_125m_out) |=> gated_clock_125m_out; endproperty
  a_span: assert property (p_span) else $error("span not 16");
  a_rsvd: assert property (p_rsvd) else $error("status reserved set");
  a_xrun: assert property (p_xrun) else $error("xrun not latched");
  a_ins: assert property (p_ins) else $error("insert not latched");
  a_del: assert property (p_del) else $error("delete not latched");
  a_clear: assert property (p_clear) else $error("irq after clear");
  a_clk50: assert property (p_clk50) else $error("clk50 not held");
  a_clk125: assert property (p_clk125) else $error("clk125 stopped early");
endmodule
bind mac_side_regs mac_side_regs_chk chk (.*);

// >>> verification/mgmt_host_model.sv
// management host model driving the register port
`timescale 1ns/1ps
module mgmt_host_model
(
  input  wire        sys_clk,
  input  wire [15:0] reg_rdata,
  input  wire        reg_rvalid,
  output reg         sw_reset,
  output reg  [7:0]  reg_page,
  output reg  [4:0]  reg_addr,
  output reg         reg_wr_en,
  output reg         reg_rd_en,
  output reg  [15:0] reg_wdata
);
  initial
  begin
    {sw_reset, reg_wr_en, reg_rd_en} = 3'h0;
    {reg_page, reg_addr, reg_wdata} = 29'h0;
  end
  // idle lines show the inverse so stale values cannot pass
  task wr(input [7:0] p, input [4:0] a, input [15:0] d);
    begin
      @(negedge sys_clk);
      {reg_page, reg_addr, reg_wdata} = {p, a, d};
      reg_wr_en = 1'b1;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
      {reg_page, reg_addr, reg_wdata} = ~{p, a, d};
    end
  endtask
  // data is taken in the cycle valid stands
  task rd(input [7:0] p, input [4:0] a, output [15:0] d, output v);
    begin
      @(negedge sys_clk);
      {reg_page, reg_addr} = {p, a};
      reg_rd_en = 1'b1;
      @(negedge sys_clk);
      d = reg_rdata;
      v = reg_rvalid;
      reg_rd_en = 1'b0;
      {reg_page, reg_addr} = ~{p, a};
    end
  endtask
  task swr;
    begin
      @(negedge sys_clk);
      sw_reset = 1'b1;
      @(negedge sys_clk);
      sw_reset = 1'b0;
    end
  endtask
  task init;
    begin
      wr(8'h00, 5'h1d, 16'h0003);
      wr(8'h00, 5'h1e, 16'h0000);
    end
  endtask
endmodule

// >>> verification/mac_side_regs_tb_top.sv
// self-checking bench for the mac-side register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_tests = n_tests + 1; \
    if ((g) !== (e)) \
    begin \
      n_mismatch = n_mismatch + 1; \
      $display("mismatch %0s exp %h got %h", nm, e, g); \
    end \
  end
module mac_side_regs_tb_top;
  reg         sys_clk, nrst, strap_clock_125m_off, strap_clock_50m_off, tv;
  reg         gigabit_mode, power_down_req, energy_detect;
  reg  [2:0]  ev;
  wire        fifo_xrun_evt = ev[2];
  wire        idle_ins_evt = ev[1];
  wire        idle_del_evt = ev[0];
  wire        sw_reset, reg_wr_en, reg_rd_en, reg_rvalid, rx_clk_run, mgmt_irq;
  wire        gated_clock_125m_out, gated_clock_50m_out;
  wire [7:0]  reg_page;
  wire [4:0]  reg_addr;
  wire [5:0]  tx_fifo_span;
  wire [15:0] reg_wdata, reg_rdata, bias_one_out, bias_two_out;
  integer     n_mismatch = 0, n_tests = 0, i;
  reg  [15:0] msk [0:2];
  mac_side_regs DUT (.*);
  mgmt_host_model host (.*);
  always #20 sys_clk = ~sys_clk;
  task cyc(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask
  task rdc(input [7:0] p, input [4:0] a, input [15:0] e);
    reg [15:0] d;
    reg        v;
    begin
      host.rd(p, a, d, v);
      `CHK("rvalid", 1'b1, v)
      `CHK("rdata", e, d)
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // a hung handshake ends the run here
  initial
  begin
    #100000;
    n_mismatch = n_mismatch + 1;
    end_of_test;
  end
  initial
  begin
    {sys_clk, nrst, strap_clock_125m_off, strap_clock_50m_off} = 4'h0;
    {gigabit_mode, power_down_req, energy_detect, ev} = 6'h00;
    {msk[0], msk[1], msk[2]} = {16'h0080, 16'h0008, 16'h0004};
    cyc(16);
    nrst = 1'b1;
    rdc(8'h02, 5'h10, 16'h0088);
    rdc(8'h02, 5'h12, 16'h0000);
    rdc(8'h02, 5'h13, 16'h0000);
    `CHK("rxclk", 1'b1, rx_clk_run)
    host.wr(8'h00, 5'h1e, 16'h5a5a);
    host.init;
    rdc(8'h00, 5'h1d, 16'h0003);
    rdc(8'h00, 5'h1e, 16'h0000);
    `CHK("bias", 16'h0003, bias_one_out)
    `CHK("bias2", 16'h0000, bias_two_out)
    rdc(8'h03, 5'h10, 16'h0000);
    $display("test reset done");
    gigabit_mode = 1'b1;
    for (i = 0; i < 4; i = i + 1)
    begin
      host.wr(8'h02, 5'h10, {i[1:0], 14'h0088});
      cyc(2);
      `CHK("span", 6'(16 + 8 * i), tx_fifo_span)
    end
    gigabit_mode = 1'b0;
    cyc(2);
    `CHK("span", 6'h10, tx_fifo_span)
    $display("test depth done");
    power_down_req = 1'b1;
    host.wr(8'h02, 5'h10, 16'h0280);
    cyc(3);
    tv = gated_clock_125m_out;
    cyc(1);
    `CHK("clk125", ~tv, gated_clock_125m_out)
    `CHK("rxclk", 1'b1, rx_clk_run)
    host.swr;
    cyc(3);
    `CHK("clk125", 1'b0, gated_clock_125m_out)
    `CHK("rxclk", 1'b0, rx_clk_run)
    power_down_req = 1'b0;
    cyc(2);
    `CHK("rxclk", 1'b1, rx_clk_run)
    energy_detect = 1'b1;
    cyc(2);
    `CHK("rxclk", 1'b0, rx_clk_run)
    host.wr(8'h02, 5'h10, 16'h0088);
    host.swr;
    cyc(3);
    `CHK("rxclk", 1'b1, rx_clk_run)
    $display("test soft reset done");
    {strap_clock_125m_off, strap_clock_50m_off} = 2'b11;
    cyc(3);
    `CHK("clk50", 1'b0, gated_clock_50m_out)
    rdc(8'h02, 5'h10, 16'h0388);
    {strap_clock_125m_off, strap_clock_50m_off} = 2'b00;
    cyc(2);
    rdc(8'h02, 5'h10, 16'h0088);
    tv = gated_clock_50m_out;
    cyc(1);
    `CHK("clk50", ~tv, gated_clock_50m_out)
    $display("test straps done");
    host.wr(8'h02, 5'h12, 16'hffff);
    rdc(8'h02, 5'h12, 16'h008c);
    for (i = 0; i < 3; i = i + 1)
    begin
      @(negedge sys_clk);
      ev = 3'b100 >> i;
      @(negedge sys_clk);
      ev = 3'b000;
      rdc(8'h02, 5'h13, msk[i]);
      `CHK("irq", 1'b1, mgmt_irq)
      rdc(8'h02, 5'h13, 16'h0000);
      `CHK("irq", 1'b0, mgmt_irq)
    end
    host.wr(8'h02, 5'h12, 16'h0000);
    @(negedge sys_clk);
    ev = 3'b111;
    @(negedge sys_clk);
    ev = 3'b000;
    cyc(2);
    `CHK("irq", 1'b0, mgmt_irq)
    host.wr(8'h02, 5'h10, 16'h0000);
    host.swr;
    rdc(8'h02, 5'h13, 16'h0000);
    rdc(8'h02, 5'h10, 16'h0080);
    $display("test events done");
    end_of_test;
  end
endmodule
